// >>> hw/amd_adc_ctrl.sv
// Serial address capture, conversion sequencing and result hold for the converter
`timescale 1ns/1ps
module amd_adc_ctrl (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic serial_din,
   input wire logic four_chan_mode,
   input wire logic hw_powerdown_pin,
   input wire logic conv_done,
   input wire logic [amd_pkg::RESULT_BITS-1:0] conv_data,
   output logic serial_dout,
   output logic serial_dout_oe,
   output logic conv_start,
   output logic [amd_pkg::SEL_W-1:0] pos_sel,
   output logic [amd_pkg::SEL_W-1:0] neg_sel,
   output logic powered_up,
   output logic result_invalid
);
   import amd_pkg::*;

   amd_state_t state_reg, state_next;
   logic [ADDR_BITS-1:0] shift_reg, shift_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [PC_CNT_W-1:0] pc_reg, pc_next;
   logic [RESULT_BITS-1:0] result_reg, result_next;
   logic [RESULT_BITS-1:0] out_reg, out_next;
   logic [SEL_W-1:0] pos_reg, pos_next;
   logic [SEL_W-1:0] neg_reg, neg_next;
   logic sw_pd_reg, sw_pd_next;
   logic first_reg, first_next;
   logic invalid_reg, invalid_next;
   logic start_reg, start_next;
   logic [ADDR_BITS-1:0] word_full;
   logic word_latch;

   amd_mux_if mux ();

   amd_mux_decode amd_mux_decode_inst (
      .mux(mux.dec)
   );

   // Word as it stands once the current bit is shifted in
   assign word_full = {serial_din, shift_reg[ADDR_BITS-1:1]};
   assign word_latch = (state_reg == ST_ADDR) && !cs_n && (cnt_reg == ADDR_LAST)
                       && !hw_powerdown_pin;
   assign mux.addr_word = word_full;
   assign mux.four_chan = four_chan_mode;

   always_comb
   begin
      state_next = state_reg;
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      pc_next = pc_reg;
      result_next = result_reg;
      out_next = out_reg;
      pos_next = pos_reg;
      neg_next = neg_reg;
      sw_pd_next = sw_pd_reg;
      first_next = first_reg;
      invalid_next = invalid_reg;
      start_next = 1'b0;
      if (hw_powerdown_pin)
      begin
         state_next = ST_RECOVER;
         pc_next = PC_ZERO;
         pos_next = SEL_NONE;
         neg_next = SEL_NONE;
      end
      else
      begin
         case (state_reg)
            ST_INIT:
            begin
               if (cs_n)
                  state_next = ST_IDLE;
            end
            ST_IDLE:
            begin
               if (!cs_n)
               begin
                  shift_next = {serial_din, shift_reg[ADDR_BITS-1:1]};
                  cnt_next = CNT_ONE;
                  state_next = ST_ADDR;
               end
            end
            ST_ADDR:
            begin
               if (cs_n)
                  state_next = ST_IDLE;
               else if (cnt_reg == ADDR_LAST)
               begin
                  shift_next = word_full;
                  if (!word_full[BIT_PU])
                  begin
                     sw_pd_next = 1'b1;
                     pos_next = SEL_NONE;
                     neg_next = SEL_NONE;
                     state_next = ST_DONE;
                  end
                  else
                  begin
                     sw_pd_next = 1'b0;
                     pos_next = mux.pos_sel;
                     neg_next = mux.neg_sel;
                     start_next = mux.word_legal;
                     state_next = mux.word_legal ? ST_CONV : ST_DONE;
                  end
               end
               else
               begin
                  shift_next = word_full;
                  cnt_next = cnt_reg + CNT_ONE;
               end
            end
            ST_CONV:
            begin
               // Conversion runs on even if select is raised meanwhile
               if (conv_done)
               begin
                  result_next = conv_data;
                  invalid_next = first_reg;
                  first_next = 1'b0;
                  if (cs_n)
                     state_next = ST_HOLD;
                  else
                  begin
                     out_next = conv_data;
                     cnt_next = RESULT_LAST;
                     state_next = ST_SHIFT;
                  end
               end
            end
            ST_HOLD:
            begin
               if (!cs_n)
               begin
                  out_next = result_reg;
                  cnt_next = RESULT_LAST;
                  state_next = ST_SHIFT;
               end
            end
            ST_SHIFT:
            begin
               if (cs_n)
                  state_next = ST_IDLE;
               else if (cnt_reg == CNT_ZERO)
                  state_next = ST_DONE;
               else
               begin
                  out_next = {out_reg[RESULT_BITS-2:0], 1'b0};
                  cnt_next = cnt_reg - CNT_ONE;
               end
            end
            ST_DONE:
            begin
               if (cs_n)
                  state_next = ST_IDLE;
            end
            ST_RECOVER:
            begin
               if (!cs_n)
                  pc_next = PC_ZERO;
               else if (pc_reg == PC_LAST)
                  state_next = ST_IDLE;
               else
                  pc_next = pc_reg + PC_ONE;
            end
            default:
               state_next = ST_INIT;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         state_reg <= ST_INIT;
         shift_reg <= ADDR_ZERO;
         cnt_reg <= CNT_ZERO;
         pc_reg <= PC_ZERO;
         result_reg <= RESULT_ZERO;
         out_reg <= RESULT_ZERO;
         pos_reg <= SEL_NONE;
         neg_reg <= SEL_NONE;
         sw_pd_reg <= 1'b1;
         first_reg <= 1'b1;
         invalid_reg <= 1'b1;
         start_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         shift_reg <= shift_next;
         cnt_reg <= cnt_next;
         pc_reg <= pc_next;
         result_reg <= result_next;
         out_reg <= out_next;
         pos_reg <= pos_next;
         neg_reg <= neg_next;
         sw_pd_reg <= sw_pd_next;
         first_reg <= first_next;
         invalid_reg <= invalid_next;
         start_reg <= start_next;
      end
   end

   assign serial_dout = out_reg[RESULT_BITS-1];
   assign serial_dout_oe = (state_reg == ST_SHIFT);
   assign conv_start = start_reg;
   assign pos_sel = pos_reg;
   assign neg_sel = neg_reg;
   assign powered_up = !sw_pd_reg && (state_reg != ST_RECOVER) && (state_reg != ST_INIT);
   assign result_invalid = invalid_reg;

   sequence held_result_s;
      (state_reg == ST_HOLD) && cs_n;
   endsequence

   sequence select_low_s;
      (state_reg == ST_HOLD) && !cs_n;
   endsequence

   sw_powerdown_a: assert property (@(posedge ref_clk) disable iff (reset)
      (word_latch && !word_full[BIT_PU]) |=> (pos_sel == SEL_NONE) && !conv_start)
      else $error("power-down word left a channel connected");
   four_ch_illegal_a: assert property (@(posedge ref_clk) disable iff (reset)
      (word_latch && four_chan_mode && word_full[BIT_SEL_HI]) |=> (pos_sel == SEL_NONE))
      else $error("four-channel word with fourth bit set was accepted");
   init_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state_reg == ST_INIT && !cs_n) |=> (state_reg == ST_INIT || hw_powerdown_pin))
      else $error("left initial state without select high");
   first_invalid_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state_reg == ST_CONV && conv_done && first_reg && !hw_powerdown_pin)
      |=> result_invalid ##1 1'b1)
      else $error("first result not flagged invalid");
   hold_tristate_a: assert property (@(posedge ref_clk) disable iff (reset)
      held_result_s |-> !serial_dout_oe ##1 $stable(result_reg))
      else $error("held result changed or output driven");
   present_msb_a: assert property (@(posedge ref_clk) disable iff (reset)
      (select_low_s ##0 !hw_powerdown_pin) |=> serial_dout_oe
      && (serial_dout == $past(result_reg[RESULT_BITS-1])))
      else $error("result not presented on select low");
   cs_reset_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state_reg == ST_SHIFT && cs_n && !hw_powerdown_pin) |=> (state_reg == ST_IDLE))
      else $error("select high did not reset the sequence");
   pd_pin_a: assert property (@(posedge ref_clk) disable iff (reset)
      hw_powerdown_pin |=> !powered_up && (pos_sel == SEL_NONE) && (neg_sel == SEL_NONE))
      else $error("device not powered down under pin");
   recover_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
      (state_reg == ST_RECOVER && !cs_n) |=> (state_reg == ST_RECOVER) && (pc_reg == PC_ZERO))
      else $error("recovery did not restart on select low");
   single_com_a: assert property (@(posedge ref_clk) disable iff (reset)
      (word_latch && word_full[BIT_PU] && word_full[BIT_MODE] && mux.word_legal)
      |=> neg_sel[COM_IDX] && $onehot(pos_sel) && $onehot(neg_sel))
      else $error("single-ended mode did not use the shared return");
endmodule : amd_adc_ctrl

// >>> hw/amd_mux_decode.sv
// Combinational decoder from address word to channel selects
`timescale 1ns/1ps
module amd_mux_decode (
   amd_mux_if.dec mux
);
   import amd_pkg::*;

   logic pu;
   logic single;
   logic odd;
   logic [1:0] pair;
   logic [CH_IDX_W-1:0] pos_ch;
   logic [CH_IDX_W-1:0] neg_ch;
   logic legal;

   always_comb
   begin
      pu = mux.addr_word[BIT_PU];
      single = mux.addr_word[BIT_MODE];
      odd = mux.addr_word[BIT_ODD];
      legal = pu && !(mux.four_chan && mux.addr_word[BIT_SEL_HI]);
      pair = mux.four_chan ? {1'b0, mux.addr_word[BIT_SEL_LO]}
                           : {mux.addr_word[BIT_SEL_HI], mux.addr_word[BIT_SEL_LO]};
      pos_ch = {pair, odd};
      neg_ch = {pair, !odd};
   end

   assign mux.word_legal = legal;

   genvar i;
   generate
      for (i = 0; i < NUM_CH; i++)
      begin : g_ch
         assign mux.pos_sel[i] = legal && (pos_ch == CH_IDX_W'(i));
         assign mux.neg_sel[i] = legal && !single && (neg_ch == CH_IDX_W'(i));
      end
   endgenerate

   assign mux.pos_sel[COM_IDX] = 1'b0;
   assign mux.neg_sel[COM_IDX] = legal && single;
endmodule : amd_mux_decode

// >>> hw/amd_mux_if.sv
// Address word and decoded channel selects between control and decoder
`timescale 1ns/1ps
interface amd_mux_if;
   logic [amd_pkg::ADDR_BITS-1:0] addr_word;
   logic four_chan;
   logic [amd_pkg::SEL_W-1:0] pos_sel;
   logic [amd_pkg::SEL_W-1:0] neg_sel;
   logic word_legal;
   modport ctrl (output addr_word, output four_chan, input pos_sel, input neg_sel,
      input word_legal);
   modport dec (input addr_word, input four_chan, output pos_sel, output neg_sel,
      output word_legal);
endinterface : amd_mux_if

// >>> hw/amd_pkg.sv
// Shared constants and types for the converter multiplexer address control block
package amd_pkg;
   localparam int ADDR_BITS = 5;
   localparam int RESULT_BITS = 11;
   localparam int NUM_CH = 8;
   localparam int SEL_W = NUM_CH + 1;
   localparam int COM_IDX = 8;
   localparam int CH_IDX_W = 3;
   localparam int BIT_PU = 0;
   localparam int BIT_MODE = 1;
   localparam int BIT_ODD = 2;
   localparam int BIT_SEL_HI = 3;
   localparam int BIT_SEL_LO = 4;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] ADDR_LAST = 4'h4;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] RESULT_LAST = 4'hA;
   localparam int CLK_PERIOD_NS = 10;
   // Power-up recovery time, in ns
   localparam int T_PC_NS = 10000;
   localparam int PC_CNT_W = 10;
   localparam logic [PC_CNT_W-1:0] PC_CYCLES =
      PC_CNT_W'((T_PC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [PC_CNT_W-1:0] PC_LAST = PC_CYCLES - 10'h001;
   localparam logic [PC_CNT_W-1:0] PC_ZERO = 10'h000;
   localparam logic [PC_CNT_W-1:0] PC_ONE = 10'h001;
   localparam logic [SEL_W-1:0] SEL_NONE = 9'h000;
   localparam logic [RESULT_BITS-1:0] RESULT_ZERO = 11'h000;
   localparam logic [ADDR_BITS-1:0] ADDR_ZERO = 5'h00;

   typedef enum logic [2:0] {
      ST_INIT = 3'b000,
      ST_IDLE = 3'b001,
      ST_ADDR = 3'b010,
      ST_CONV = 3'b011,
      ST_HOLD = 3'b100,
      ST_SHIFT = 3'b101,
      ST_DONE = 3'b110,
      ST_RECOVER = 3'b111
   } amd_state_t;
endpackage : amd_pkg

// >>> testbench/amd_adc_ctrl_test.sv
// Self-checking bench for the converter address control
`timescale 1ns/1ps
module amd_adc_ctrl_test;
   import amd_pkg::*;
   logic ref_clk, reset, cs_n, serial_din, four_chan_mode, hw_powerdown_pin, first;
   logic conv_done, serial_dout, serial_dout_oe, conv_start, powered_up, result_invalid;
   logic [RESULT_BITS-1:0] conv_data, exp_data, got;
   logic [SEL_W-1:0] pos_sel, neg_sel;
   int err_count = 0;
   int cmp_count = 0;
   amd_adc_ctrl amd_adc_ctrl_inst (.ref_clk(ref_clk), .reset(reset), .cs_n(cs_n),
      .serial_din(serial_din), .four_chan_mode(four_chan_mode),
      .hw_powerdown_pin(hw_powerdown_pin), .conv_done(conv_done), .conv_data(conv_data),
      .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe), .conv_start(conv_start),
      .pos_sel(pos_sel), .neg_sel(neg_sel), .powered_up(powered_up),
      .result_invalid(result_invalid));
   amd_core_model amd_core_model_inst (.ref_clk(ref_clk), .reset(reset),
      .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data));
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      if (conv_done === 1'b1)
         exp_data <= conv_data;
   task automatic chk_sel(input logic [2*SEL_W-1:0] g, input logic [2*SEL_W-1:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH t=%0t sel got %h exp %h", $time, g, e);
      end
   endtask : chk_sel
   task automatic chk_word(input logic [RESULT_BITS-1:0] g, input logic [RESULT_BITS-1:0] e);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH t=%0t data got %h exp %h", $time, g, e);
      end
   endtask : chk_word
   task automatic chk_flag(input logic g, input logic e);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH t=%0t flag got %h exp %h", $time, g, e);
      end
   endtask : chk_flag
   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // Word bits: [4] first (power-up) down to [0] fifth
   function automatic logic [2*SEL_W-1:0] exp_sel(input logic [4:0] w, input logic four);
      logic [2:0] p;
      logic [SEL_W-1:0] pos, neg;
      p = {four ? 1'b0 : w[1], w[0], 1'b0};
      pos = 9'h001 << (p | 3'(w[2]));
      neg = w[3] ? 9'h100 : 9'h001 << (p | 3'(!w[2]));
      if (!w[4] || (four && w[1]))
         return 18'h0_0000;
      return {pos, neg};
   endfunction : exp_sel
   task automatic shift(input logic [4:0] w);
      for (int i = 4; i >= 0; i--)
      begin
         cs_n = 1'b0;
         serial_din = w[i];
         @(negedge ref_clk);
      end
   endtask : shift
   task automatic run(input logic [4:0] w, input logic hold);
      int n;
      logic [2*SEL_W-1:0] e;
      n = 0;
      e = exp_sel(w, four_chan_mode);
      shift(w);
      chk_sel({pos_sel, neg_sel}, e);
      chk_flag(conv_start, e != 18'h0_0000);
      if (e != 18'h0_0000)
      begin
         chk_flag(powered_up, 1'b1);
         cs_n = hold;
         if (hold)
         begin
            while (conv_done !== 1'b1 && n < 100)
            begin
               n++;
               @(negedge ref_clk);
            end
            repeat (4) @(negedge ref_clk);
            chk_flag(serial_dout_oe, 1'b0);
            cs_n = 1'b0;
         end
         while (serial_dout_oe !== 1'b1 && n < 100)
         begin
            n++;
            @(negedge ref_clk);
         end
         chk_flag(serial_dout_oe, 1'b1);
         for (int i = 10; i >= 0; i--)
         begin
            got[i] = serial_dout;
            @(negedge ref_clk);
         end
         chk_word(got, exp_data);
         chk_flag(serial_dout_oe, 1'b0);
         chk_flag(result_invalid, first);
         first = 1'b0;
      end
      else if (!w[4])
         chk_flag(powered_up, 1'b0);
      // one clock high resets the sequence
      cs_n = 1'b1;
      @(negedge ref_clk);
   endtask : run
   initial
   begin
      reset = 1'b1;
      cs_n = 1'b0;
      serial_din = 1'b0;
      four_chan_mode = 1'b0;
      hw_powerdown_pin = 1'b0;
      first = 1'b1;
      repeat (6) @(negedge ref_clk);
      reset = 1'b0;
      chk_flag(result_invalid, 1'b1);
      // select low from start: no word taken
      shift(5'h18);
      chk_sel({pos_sel, neg_sel}, 18'h0_0000);
      cs_n = 1'b1;
      @(negedge ref_clk);
      // word cut short by select high is dropped
      cs_n = 1'b0;
      serial_din = 1'b1;
      repeat (3) @(negedge ref_clk);
      cs_n = 1'b1;
      @(negedge ref_clk);
      chk_sel({pos_sel, neg_sel}, 18'h0_0000);
      for (int m = 0; m < 2; m++)
      begin
         four_chan_mode = m[0];
         for (int w = 0; w < 32; w++)
            run(w[4:0], w[1] ^ w[2]);
      end
      run(5'h1D, 1'b0);
      hw_powerdown_pin = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk_sel({pos_sel, neg_sel}, 18'h0_0000);
      chk_flag(powered_up, 1'b0);
      hw_powerdown_pin = 1'b0;
      repeat (500) @(negedge ref_clk);
      shift(5'h18);
      chk_sel({pos_sel, neg_sel}, 18'h0_0000);
      cs_n = 1'b1;
      repeat (PC_CYCLES + 2) @(negedge ref_clk);
      run(5'h1D, 1'b0);
      finish_test();
   end
   // Roughly fifteen times the expected run length
   initial
   begin
      #400000;
      err_count++;
      finish_test();
   end
endmodule : amd_adc_ctrl_test

// >>> testbench/amd_core_model.sv
// Converter core model: answers each start request with one result
`timescale 1ns/1ps
module amd_core_model #(
   parameter int CONV_CYCLES = 12
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic conv_start,
   output logic conv_done,
   output logic [amd_pkg::RESULT_BITS-1:0] conv_data
);
   import amd_pkg::*;
   int cnt;
   logic [RESULT_BITS-1:0] val;
   always @(posedge ref_clk)
   begin
      conv_done <= 1'b0;
      // Outside the strobe the bus shows junk, not the old result
      conv_data <= ~val;
      if (reset)
      begin
         cnt <= 0;
         val <= 11'h5A3;
      end
      else if (conv_start)
         cnt <= CONV_CYCLES;
      else if (cnt == 1)
      begin
         cnt <= 0;
         conv_done <= 1'b1;
         conv_data <= val;
         val <= val + 11'h1B7;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
   end
endmodule : amd_core_model
